// ---- rtl/tmc_top.sv ----
/*
 * Configuration logic of a JTAG TAP master: mode and loopback register,
 * divider and retiming register, discrete-control register, the asynchronous
 * 8-bit host port that reaches them, TCK generation and the TAP pin mux.
 * Assumes a command engine on the same clock supplies busy, scan and buffer
 * state and its own TAP levels; other host addresses are served elsewhere.
 */
//
// Contract
// - Output-disable bit 1 floats TCK, TDO, TMS, TRST; 0 drives them while the hardware enable pin is low.
// - Loopback 00 feeds the TDI buffer from the TDI pin.
// - Loopback 01 feeds the TMS generator to TDI buffer; TMS, TDO high.
// - Loopback 10 feeds TDO buffer to TDI buffer; TMS, TDO high; 11 reserved.
// - Mode 000 runs TAP outputs from the command, TCK toggling always.
// - Free-running scan stall sends the target to Pause until serviced.
// - Mode 001 pulses TCK only when the engine needs it, else low.
// - Gated scan stall keeps Shift state with TCK stopped until serviced.
// - Mode 010 drives TAP outputs from the discrete register; 011-111 reserved.
// - TCK equals the input clock divided by two to the divisor field; field 0 divides by two, as field 1 does.
// - Every reset sets the divisor field to 4.
// - TDI sampling waits retiming-count TCK cycles after Shift entry.
// - Configuration writes stall while a command runs; reads always allowed.
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_top
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_SRST,
	// Host bus pins
	input wire logic I_STRB_N,
	input wire logic I_RD_WR_N,
	input wire logic [2:0] I_ADDR,
	input wire logic [7:0] I_DATA,
	output logic [7:0] O_DATA,
	output logic O_DATA_OE_N,
	output logic O_RDY,
	// TAP pins
	input wire logic I_TDI,
	input wire logic I_HW_OUTPUT_ENABLE_PIN_N,
	output logic O_TCK,
	output logic O_TMS,
	output logic O_TDO,
	output logic O_TRST_N,
	output logic O_TAP_OE_N,
	// Command engine status
	input wire logic I_SW_RESET,
	input wire logic I_CMD_BUSY,
	input wire logic I_SCAN_ACTIVE,
	input wire logic I_SHIFT_ENTRY,
	input wire logic I_BUF_STALL,
	input wire logic I_ENG_TCK_REQ,
	// Command engine TAP levels
	input wire logic I_ENG_TMS,
	input wire logic I_ENG_TDO,
	input wire logic I_ENG_TRST_N,
	input wire logic I_TDO_BUF_BIT,
	// Configuration and timing toward the engine
	output logic [2:0] O_MODE,
	output logic O_PAUSE_REQ,
	output logic O_TCK_RISE,
	output logic O_TCK_FALL,
	output logic O_TDI_BIT,
	output logic O_TDI_SAMPLE
);

	tmc_core_if cif();

	tmc_byte_t cfg_a;
	tmc_byte_t cfg_b;
	tmc_byte_t disc;
	logic disc_tdi;
	logic disc_pulse;
	tmc_bus_e bus_state;
	tmc_bus_e next_bus_state;
	logic strb_q;
	logic [3:0] delay_cnt;

	logic strb_n;
	logic rd_wr_n;
	logic [2:0] addr;
	tmc_byte_t wdata;
	logic toe_n;
	logic tdi_pin;
	logic strb_fall;
	logic strb_rise;
	logic guarded_addr;
	logic commit;
	logic any_reset;
	logic [2:0] mode;
	logic [1:0] loopback_select;
	logic next_run;
	logic next_tms;
	logic next_tdo;
	logic next_trst_n;
	logic next_tdi_bit;
	tmc_byte_t next_rdata;

	// Pin synchroniser and TCK generator
	tmc_pin_sync u_sync (
		.i_clk(I_REF_CLK),
		.i_srst(I_SRST),
		.bus(cif.sync)
	);

	tmc_tck_gen u_tck (
		.i_clk(I_REF_CLK),
		.i_srst(I_SRST),
		.gen(cif.gen)
	);

	// Pin word into the synchroniser
	assign cif.raw = {I_TDI, I_HW_OUTPUT_ENABLE_PIN_N, I_DATA, I_ADDR, I_RD_WR_N, I_STRB_N};

	// Synchronised pin fields
	assign strb_n = cif.stable[`TMC_SB_STRB];
	assign rd_wr_n = cif.stable[`TMC_SB_RW];
	assign addr = cif.stable[`TMC_SB_ADDR +: 3];
	assign wdata = cif.stable[`TMC_SB_DATA +: 8];
	assign toe_n = cif.stable[`TMC_SB_TOE];
	assign tdi_pin = cif.stable[`TMC_SB_TDI];

	// Configuration fields
	assign mode = cfg_a[`TMC_A_MODE_LO +: 3];
	assign loopback_select = cfg_a[`TMC_A_LOOPBACK_SELECT_LO +: 2];
	assign any_reset = I_SRST | I_SW_RESET;
	assign cif.div_exp = cfg_b[`TMC_B_DIV_LO +: 3];

	// Strobe edges
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			strb_q <= 1'b1;
		end else begin
			strb_q <= strb_n;
		end
	end

	assign strb_fall = strb_q & ~strb_n;
	assign strb_rise = ~strb_q & strb_n;

	// Registers whose writes wait for the running command
	assign guarded_addr = (addr == `TMC_ADDR_CFG_A) || (addr == `TMC_ADDR_CFG_B)
		|| (addr == `TMC_ADDR_DISC);

	// Host access sequencing
	always_comb begin
		next_bus_state = bus_state;
		case (bus_state)
			TMC_BUS_IDLE: begin
				if (strb_fall && rd_wr_n) begin
					next_bus_state = TMC_BUS_READ;
				end else if (strb_fall && guarded_addr && I_CMD_BUSY) begin
					next_bus_state = TMC_BUS_HOLD;
				end else if (strb_fall) begin
					next_bus_state = TMC_BUS_WRITE;
				end
			end
			TMC_BUS_READ: begin
				if (strb_rise) begin
					next_bus_state = TMC_BUS_IDLE;
				end
			end
			TMC_BUS_WRITE: begin
				if (strb_rise) begin
					next_bus_state = TMC_BUS_IDLE;
				end
			end
			TMC_BUS_HOLD: begin
				if (strb_rise) begin
					next_bus_state = TMC_BUS_IDLE;
				end else if (!I_CMD_BUSY) begin
					next_bus_state = TMC_BUS_WRITE;
				end
			end
			default: begin
				next_bus_state = TMC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			bus_state <= TMC_BUS_IDLE;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// Write commits on the closing strobe edge only
	assign commit = (bus_state == TMC_BUS_WRITE) && strb_rise && !I_CMD_BUSY;

	// Configuration registers; reserved bits stay zero
	always_ff @(posedge I_REF_CLK) begin
		if (any_reset) begin
			cfg_a <= `TMC_CFG_A_RST;
			cfg_b <= `TMC_CFG_B_RST;
		end else if (commit && addr == `TMC_ADDR_CFG_A) begin
			cfg_a <= wdata & `TMC_CFG_A_WMASK;
		end else if (commit && addr == `TMC_ADDR_CFG_B) begin
			cfg_b <= wdata & `TMC_CFG_B_WMASK;
		end
	end

	// Discrete-control register
	always_ff @(posedge I_REF_CLK) begin
		if (any_reset) begin
			disc <= `TMC_DISC_RST;
		end else if (commit && addr == `TMC_ADDR_DISC) begin
			disc <= wdata & `TMC_DISC_WMASK;
		end
	end

	// One TCK pulse per discrete write in mode 010; a new write wins over the clear
	always_ff @(posedge I_REF_CLK) begin
		if (any_reset) begin
			disc_pulse <= 1'b0;
		end else if (commit && addr == `TMC_ADDR_DISC && mode == TMC_MODE_DISC) begin
			disc_pulse <= 1'b1;
		end else if (cif.fall) begin
			disc_pulse <= 1'b0;
		end
	end

	// TDI captured on each rising TCK for discrete readback
	always_ff @(posedge I_REF_CLK) begin
		if (any_reset) begin
			disc_tdi <= 1'b0;
		end else if (cif.rise) begin
			disc_tdi <= tdi_pin;
		end
	end

	// TCK run request by mode; discrete run stops on its own fall, one pulse only
	always_comb begin
		next_run = 1'b0;
		case (mode)
			TMC_MODE_FREE: next_run = 1'b1;
			TMC_MODE_GATED: next_run = I_ENG_TCK_REQ & ~I_BUF_STALL;
			TMC_MODE_DISC: next_run = disc_pulse & ~cif.fall;
			default: next_run = 1'b0;
		endcase
	end

	assign cif.run = next_run;

	// TAP output levels by mode and loopback
	always_comb begin
		next_tms = I_ENG_TMS;
		next_tdo = I_ENG_TDO;
		next_trst_n = I_ENG_TRST_N;
		if (mode == TMC_MODE_DISC) begin
			next_tms = disc[`TMC_D_TMS_BIT];
			next_tdo = disc[`TMC_D_TDO_BIT];
			next_trst_n = disc[`TMC_D_TRST_BIT];
		end
		if (loopback_select == TMC_LB_TMS || loopback_select == TMC_LB_TDO) begin
			next_tms = 1'b1;
			next_tdo = 1'b1;
		end
	end

	// TDI buffer source
	always_comb begin
		case (loopback_select)
			TMC_LB_PIN: next_tdi_bit = tdi_pin;
			TMC_LB_TMS: next_tdi_bit = I_ENG_TMS;
			TMC_LB_TDO: next_tdi_bit = I_TDO_BUF_BIT;
			default: next_tdi_bit = tdi_pin;
		endcase
	end

	// TAP pins and enable
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			O_TMS <= 1'b1;
			O_TDO <= 1'b1;
			O_TRST_N <= 1'b1;
			O_TAP_OE_N <= 1'b1;
		end else begin
			O_TMS <= next_tms;
			O_TDO <= next_tdo;
			O_TRST_N <= next_trst_n;
			O_TAP_OE_N <= cfg_a[`TMC_A_DIS_BIT] | toe_n;
		end
	end

	assign O_TCK = cif.tck;
	assign O_TCK_RISE = cif.rise;
	assign O_TCK_FALL = cif.fall;
	assign O_MODE = mode;

	// Retiming delay counted in TCK rises from Shift entry
	always_ff @(posedge I_REF_CLK) begin
		if (any_reset) begin
			delay_cnt <= 4'h0;
		end else if (I_SHIFT_ENTRY) begin
			delay_cnt <= cfg_b[`TMC_B_RETIME_DELAY_COUNT_LO +: 4];
		end else if (cif.rise && delay_cnt != 4'h0) begin
			delay_cnt <= delay_cnt - 4'h1;
		end
	end

	// TDI bit, sample strobe and pause request toward the engine
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			O_TDI_BIT <= 1'b0;
			O_TDI_SAMPLE <= 1'b0;
			O_PAUSE_REQ <= 1'b0;
		end else begin
			O_TDI_BIT <= next_tdi_bit;
			O_TDI_SAMPLE <= cif.rise & I_SCAN_ACTIVE & ~I_SHIFT_ENTRY
				& (delay_cnt == 4'h0);
			O_PAUSE_REQ <= (mode == TMC_MODE_FREE) & I_SCAN_ACTIVE & I_BUF_STALL;
		end
	end

	// Read data by address; unserved addresses read zero
	always_comb begin
		case (addr)
			`TMC_ADDR_CFG_A: next_rdata = cfg_a;
			`TMC_ADDR_CFG_B: next_rdata = cfg_b;
			`TMC_ADDR_DISC: next_rdata = {disc[7:2], disc_tdi, disc[0]};
			default: next_rdata = 8'h00;
		endcase
	end

	// Host data bus and ready; reads are never held off
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			O_DATA <= 8'h00;
			O_DATA_OE_N <= 1'b1;
			O_RDY <= 1'b1;
		end else begin
			O_DATA <= next_rdata;
			O_DATA_OE_N <= ~(next_bus_state == TMC_BUS_READ);
			O_RDY <= ~(next_bus_state == TMC_BUS_HOLD);
		end
	end

endmodule: tmc_top

// ---- rtl/tmc_defines.svh ----
/*
 * Constants of the TAP master configuration block: register addresses,
 * field positions, reset values and the layout of the synchronised pin word.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Register addresses on the 3-bit host address
`define TMC_ADDR_CFG_A 3'h0
`define TMC_ADDR_CFG_B 3'h1
`define TMC_ADDR_DISC 3'h7

// Reset values
`define TMC_CFG_A_RST 8'h00
`define TMC_CFG_B_RST 8'h80
`define TMC_DISC_RST 8'h00

// Writable bits; reserved bits are stored as zero
`define TMC_CFG_A_WMASK 8'h3f
`define TMC_CFG_B_WMASK 8'hef
`define TMC_DISC_WMASK 8'h0d

// Field positions in the first configuration register
`define TMC_A_DIS_BIT 5
`define TMC_A_LOOPBACK_SELECT_LO 3
`define TMC_A_MODE_LO 0

// Field positions in the second configuration register
`define TMC_B_DIV_LO 5
`define TMC_B_RETIME_DELAY_COUNT_LO 0

// Field positions in the discrete-control register
`define TMC_D_TRST_BIT 3
`define TMC_D_TMS_BIT 2
`define TMC_D_TDI_BIT 1
`define TMC_D_TDO_BIT 0

// Layout of the synchronised pin word
`define TMC_SYNC_W 15
`define TMC_SYNC_RST 15'h2001
`define TMC_SB_STRB 0
`define TMC_SB_RW 1
`define TMC_SB_ADDR 2
`define TMC_SB_DATA 5
`define TMC_SB_TOE 13
`define TMC_SB_TDI 14

`endif

// ---- rtl/tmc_pkg.sv ----
/*
 * Types and shared arithmetic of the TAP master configuration block.
 * Assumes the defines header is compiled alongside.
 */
package tmc_pkg;

	// Test modes
	typedef enum logic [2:0] {
		TMC_MODE_FREE = 3'b000,
		TMC_MODE_GATED = 3'b001,
		TMC_MODE_DISC = 3'b010
	} tmc_mode_e;

	// Loopback sources of the TDI buffer
	typedef enum logic [1:0] {
		TMC_LB_PIN = 2'b00,
		TMC_LB_TMS = 2'b01,
		TMC_LB_TDO = 2'b10
	} tmc_loop_e;

	// Host access states
	typedef enum logic [1:0] {
		TMC_BUS_IDLE = 2'b00,
		TMC_BUS_READ = 2'b01,
		TMC_BUS_WRITE = 2'b10,
		TMC_BUS_HOLD = 2'b11
	} tmc_bus_e;

	typedef logic [7:0] tmc_byte_t;

	// Half period of TCK minus one, in reference clocks, for exponent e
	function automatic logic [6:0] tmc_half_period(input logic [2:0] e);
		logic [7:0] one_hot;
		one_hot = 8'h01 << (e - 3'h1);
		tmc_half_period = (e == 3'h0) ? 7'h00 : 7'(one_hot - 8'h01);
	endfunction: tmc_half_period

endpackage: tmc_pkg

// ---- rtl/tmc_core_if.sv ----
/*
 * Carrier between the configuration core, its pin synchroniser and its
 * TCK generator. Assumes all three run on the same reference clock.
 */
`timescale 1ns/1ps
`include "tmc_defines.svh"

interface tmc_core_if;
	// Pin word before and after synchronisation
	logic [`TMC_SYNC_W-1:0] raw;
	logic [`TMC_SYNC_W-1:0] stable;
	// TCK generator control and result
	logic [2:0] div_exp;
	logic run;
	logic tck;
	logic rise;
	logic fall;

	modport sync (input raw, output stable);
	modport gen (input div_exp, run, output tck, rise, fall);
	modport core (output raw, div_exp, run, input stable, tck, rise, fall);
endinterface: tmc_core_if

// ---- rtl/tmc_pin_sync.sv ----
/*
 * Three-stage synchroniser for the asynchronous host and TAP input pins.
 * A bit changes once the second and third stages agree.
 * Assumes the pins are quasi-static relative to the reference clock.
 */
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_pin_sync
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Pin word
	tmc_core_if.sync bus
);

	logic [`TMC_SYNC_W-1:0] stage1;
	logic [`TMC_SYNC_W-1:0] stage2;
	logic [`TMC_SYNC_W-1:0] stage3;
	logic [`TMC_SYNC_W-1:0] stable;
	logic [`TMC_SYNC_W-1:0] agree;

	// Synchroniser chain
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			stage1 <= `TMC_SYNC_RST;
			stage2 <= `TMC_SYNC_RST;
			stage3 <= `TMC_SYNC_RST;
		end else begin
			stage1 <= bus.raw;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Accept a bit only where stages two and three agree
	assign agree = ~(stage2 ^ stage3);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			stable <= `TMC_SYNC_RST;
		end else begin
			stable <= (stage3 & agree) | (stable & ~agree);
		end
	end

	assign bus.stable = stable;

endmodule: tmc_pin_sync

// ---- rtl/tmc_tck_gen.sv ----
/*
 * TCK generator: divides the reference clock by a power of two and parks
 * TCK low once it is low while run is low. Assumes run is driven on the same clock.
 */
`timescale 1ns/1ps

module tmc_tck_gen
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Generator control and result
	tmc_core_if.gen gen
);

	logic [6:0] cnt;
	logic tck;
	logic rise;
	logic fall;

	// Divider and TCK level; gating only takes effect in the low phase
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt <= 7'h00;
			tck <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			rise <= 1'b0;
			fall <= 1'b0;
			if (!tck && !gen.run) begin
				cnt <= 7'h00; // Parked low
			end else if (cnt >= tmc_half_period(gen.div_exp)) begin
				cnt <= 7'h00;
				tck <= ~tck;
				rise <= ~tck;
				fall <= tck;
			end else begin
				cnt <= cnt + 7'h01;
			end
		end
	end

	assign gen.tck = tck;
	assign gen.rise = rise;
	assign gen.fall = fall;

endmodule: tmc_tck_gen

// ---- sim/tmc_top_asserts.sv ----
/* Checker of the TAP master configuration pins.
   Assumes it is bound to tmc_top and everything runs on the reference clock. */
`timescale 1ns/1ps
module tmc_top_asserts
	import tmc_pkg::*;
(
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_SRST,
	// Watched inputs
	input wire logic I_STRB_N,
	input wire logic I_HW_OUTPUT_ENABLE_PIN_N,
	input wire logic I_CMD_BUSY,
	input wire logic I_SCAN_ACTIVE,
	input wire logic I_SHIFT_ENTRY,
	input wire logic I_BUF_STALL,
	input wire logic I_ENG_TCK_REQ,
	// Watched outputs
	input wire logic O_DATA_OE_N,
	input wire logic O_RDY,
	input wire logic O_TCK,
	input wire logic O_TAP_OE_N,
	input wire logic [2:0] O_MODE,
	input wire logic O_PAUSE_REQ,
	input wire logic O_TCK_RISE,
	input wire logic O_TCK_FALL,
	input wire logic O_TDI_SAMPLE
);
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (I_SRST);
	logic [7:0] still_cnt;
	// Cycles since TCK last moved in free mode
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST || O_MODE != TMC_MODE_FREE || O_TCK_RISE || O_TCK_FALL) begin
			still_cnt <= 8'h00;
		end else begin
			still_cnt <= still_cnt + 8'h01;
		end
	end
	// Gated mode with no clock wanted
	sequence gated_idle;
		O_MODE == TMC_MODE_GATED && (!I_ENG_TCK_REQ || I_BUF_STALL);
	endsequence
	// TAP pins and clock
	chk_hw_pin_float: assert property (I_HW_OUTPUT_ENABLE_PIN_N [*6] |-> O_TAP_OE_N)
		else $error("TAP outputs driven with hw enable off");
	chk_tck_rise_pulse: assert property (O_TCK_RISE == $rose(O_TCK))
		else $error("rise pulse not on TCK rise");
	chk_tck_fall_pulse: assert property (O_TCK_FALL == $fell(O_TCK))
		else $error("fall pulse not on TCK fall");
	chk_free_tck_runs: assert property (still_cnt <= 8'h40)
		else $error("TCK stopped in free mode");
	chk_gated_tck_park: assert property (gated_idle [*3] ##0 !O_TCK |=> !O_TCK)
		else $error("TCK moved while gated off");
	chk_pause_req_lag: assert property (O_PAUSE_REQ ==
		$past(O_MODE == TMC_MODE_FREE && I_SCAN_ACTIVE && I_BUF_STALL))
		else $error("pause request wrong");
	// Host bus and retiming
	chk_rdy_busy_free: assert property (!I_CMD_BUSY [*2] |-> O_RDY)
		else $error("ready low without busy");
	chk_data_bus_float: assert property (I_STRB_N [*6] |-> O_DATA_OE_N)
		else $error("data bus driven without strobe");
	chk_tdi_sample_cause: assert property (O_TDI_SAMPLE |->
		$past(O_TCK_RISE) && $past(I_SCAN_ACTIVE) && !$past(I_SHIFT_ENTRY))
		else $error("TDI sample without rise in scan");
endmodule: tmc_top_asserts

bind tmc_top tmc_top_asserts i_chk (.*);

// ---- sim/tmc_scan_target.sv ----
/* Model of one target scan chain on the far side of the TAP.
   Assumes the bench resolves floated TAP lines to their pulls. */
`timescale 1ns/1ps
module tmc_scan_target (
	// TAP lines as seen at the target
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_trst_n,
	// Scan output toward the master
	output logic o_tdo
);
	logic [7:0] chain;
	logic out_bit;
	// Shift on TCK rise, cleared by TRST
	always @(posedge i_tck or negedge i_trst_n) begin
		if (!i_trst_n) begin
			chain <= 8'h00;
		end else begin
			chain <= {chain[6:0], i_tdi};
		end
	end
	// Output changes on TCK fall
	always @(negedge i_tck or negedge i_trst_n) begin
		if (!i_trst_n) begin
			out_bit <= 1'b0;
		end else begin
			out_bit <= chain[7];
		end
	end
	// Driven only while shifting, else the pull-up wins
	assign o_tdo = (i_trst_n && !i_tms) ? out_bit : 1'b1;
endmodule: tmc_scan_target

// ---- sim/tap_master_configuration_tb_top.sv ----
/* Testbench of the TAP master configuration block: host accesses, TAP levels, TCK.
   Assumes the checker is bound and the target model is compiled. */
`timescale 1ns/1ps
`include "tmc_defines.svh"
module tap_master_configuration_tb_top;
	logic I_REF_CLK = 1'b0, I_SRST = 1'b1, I_STRB_N = 1'b1, I_RD_WR_N = 1'b1;
	logic [2:0] I_ADDR = 3'h0;
	logic [7:0] I_DATA = 8'h00;
	logic I_HW_OUTPUT_ENABLE_PIN_N = 1'b1, I_SW_RESET = 1'b0, I_CMD_BUSY = 1'b0;
	logic I_SCAN_ACTIVE = 1'b0, I_SHIFT_ENTRY = 1'b0, I_BUF_STALL = 1'b0;
	logic I_ENG_TCK_REQ = 1'b0, I_ENG_TMS = 1'b1, I_ENG_TDO = 1'b0;
	logic I_ENG_TRST_N = 1'b1, I_TDO_BUF_BIT = 1'b0;
	wire I_TDI;
	logic [7:0] O_DATA;
	logic [2:0] O_MODE;
	logic O_DATA_OE_N, O_RDY, O_TCK, O_TMS, O_TDO, O_TRST_N, O_TAP_OE_N;
	logic O_PAUSE_REQ, O_TCK_RISE, O_TCK_FALL, O_TDI_BIT, O_TDI_SAMPLE;
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_rise = 0;
	int k;
	int i;
	// Floated TAP lines: TCK pulled down, the rest pulled up
	wire tck_line = O_TAP_OE_N ? 1'b0 : O_TCK;
	wire tms_line = O_TAP_OE_N ? 1'b1 : O_TMS;
	wire tdo_line = O_TAP_OE_N ? 1'b1 : O_TDO;
	wire trst_line = O_TAP_OE_N ? 1'b1 : O_TRST_N;
	tmc_top i_dut (.*);
	tmc_scan_target i_tgt (.i_tck(tck_line), .i_tms(tms_line), .i_tdi(tdo_line),
		.i_trst_n(trst_line), .o_tdo(I_TDI));
	// Verdict and end of run
	task end_sim();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask: end_sim
	// One comparison
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask: chk
	// Host write, ready looked at before the strobe rises
	task wr(input logic [2:0] a, input logic [7:0] d, input logic rdy = 1'b1);
		I_RD_WR_N = 1'b0;
		I_ADDR = a;
		I_DATA = d;
		I_STRB_N = 1'b0;
		repeat (8) @(negedge I_REF_CLK);
		chk("ready", 8'(rdy), 8'(O_RDY));
		I_STRB_N = 1'b1;
		repeat (8) @(negedge I_REF_CLK);
	endtask: wr
	// Host read with bounded wait for the bus drive
	task rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
		I_RD_WR_N = 1'b1;
		I_ADDR = a;
		I_STRB_N = 1'b0;
		k = 0;
		while (O_DATA_OE_N !== 1'b0 && k < 20) begin
			@(negedge I_REF_CLK);
			k++;
		end
		chk("read drive", 8'h00, 8'(O_DATA_OE_N));
		chk("read data", exp, O_DATA & m);
		I_STRB_N = 1'b1;
		repeat (8) @(negedge I_REF_CLK);
	endtask: rd
	// Cycles up to the next TCK rise
	task nxt_rise();
		k = 0;
		do begin
			@(negedge I_REF_CLK);
			k++;
		end while (O_TCK_RISE !== 1'b1 && k < 300);
	endtask: nxt_rise
	// TCK period once the divider has settled
	task per(input logic [7:0] want);
		repeat (3) nxt_rise();
		chk("tck period", want, 8'(k));
	endtask: per
	// TAP levels and TDI source after settling
	task tap(input logic [3:0] want, input logic [3:0] m = 4'hf);
		repeat (8) @(negedge I_REF_CLK);
		chk("tap levels", 8'(want & m), 8'({O_TRST_N, O_TMS, O_TDO, O_TDI_BIT} & m));
	endtask: tap
	// TCK rises over 40 cycles
	task rises();
		repeat (4) @(negedge I_REF_CLK);
		k = 0;
		repeat (40) begin
			@(negedge I_REF_CLK);
			if (O_TCK_RISE === 1'b1) k++;
		end
	endtask: rises
	// Clock and run limit
	always #2 I_REF_CLK = ~I_REF_CLK;
	// TCK rises seen over the whole run
	always @(negedge I_REF_CLK) begin
		if (O_TCK_RISE === 1'b1) n_rise++;
	end
	always @(posedge I_REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(negedge I_REF_CLK);
		I_SRST = 1'b0;
		repeat (4) @(negedge I_REF_CLK);
		rd(`TMC_ADDR_CFG_A, 8'h00);
		rd(`TMC_ADDR_CFG_B, 8'h80);
		rd(`TMC_ADDR_DISC, 8'h00, 8'hfd);
		per(8'h10);
		chk("tap float", 8'h01, 8'(O_TAP_OE_N));
		I_HW_OUTPUT_ENABLE_PIN_N = 1'b0;
		repeat (8) @(negedge I_REF_CLK);
		chk("tap float", 8'h00, 8'(O_TAP_OE_N));
		wr(`TMC_ADDR_CFG_A, 8'h20);
		chk("tap float", 8'h01, 8'(O_TAP_OE_N));
		wr(`TMC_ADDR_CFG_A, 8'h00);
		chk("tap float", 8'h00, 8'(O_TAP_OE_N));
		wr(3'h3, 8'hff);
		rd(`TMC_ADDR_CFG_A, 8'h00);
		wr(`TMC_ADDR_CFG_B, 8'h8f);
		rd(`TMC_ADDR_CFG_B, 8'h8f);
		for (i = 0; i < 8; i++) begin
			wr(`TMC_ADDR_CFG_B, {i[2:0], 5'h00});
			per(i == 0 ? 8'h02 : 8'h01 << i);
		end
		I_SW_RESET = 1'b1;
		@(negedge I_REF_CLK);
		I_SW_RESET = 1'b0;
		rd(`TMC_ADDR_CFG_B, 8'h80);
		per(8'h10);
		I_CMD_BUSY = 1'b1;
		wr(`TMC_ADDR_CFG_B, 8'h44, 1'b0);
		rd(`TMC_ADDR_CFG_B, 8'h80);
		I_CMD_BUSY = 1'b0;
		wr(`TMC_ADDR_CFG_B, 8'h02);
		rd(`TMC_ADDR_CFG_B, 8'h02);
		nxt_rise();
		I_SCAN_ACTIVE = 1'b1;
		I_SHIFT_ENTRY = 1'b1;
		@(negedge I_REF_CLK);
		I_SHIFT_ENTRY = 1'b0;
		k = 0;
		i = 0;
		while (O_TDI_SAMPLE !== 1'b1 && i < 50) begin
			if (O_TCK_RISE === 1'b1) k++;
			@(negedge I_REF_CLK);
			i++;
		end
		chk("retime rises", 8'h03, 8'(k));
		I_BUF_STALL = 1'b1;
		@(negedge I_REF_CLK);
		chk("pause request", 8'h01, 8'(O_PAUSE_REQ));
		wr(`TMC_ADDR_CFG_A, 8'h01);
		chk("mode", 8'h01, 8'(O_MODE));
		chk("pause request", 8'h00, 8'(O_PAUSE_REQ));
		I_ENG_TCK_REQ = 1'b1;
		rises();
		chk("stalled rises", 8'h00, 8'(k));
		I_BUF_STALL = 1'b0;
		rises();
		chk("gated running", 8'h01, 8'(k > 15));
		I_ENG_TCK_REQ = 1'b0;
		rises();
		chk("gated parked", 8'h00, 8'(k));
		I_SCAN_ACTIVE = 1'b0;
		wr(`TMC_ADDR_CFG_A, 8'h02);
		rises();
		chk("discrete idle rises", 8'h00, 8'(k));
		I_ENG_TMS = 1'b0;
		wr(`TMC_ADDR_CFG_A, 8'h08);
		tap(4'he);
		I_ENG_TMS = 1'b1;
		tap(4'hf);
		I_ENG_TMS = 1'b0;
		I_TDO_BUF_BIT = 1'b1;
		wr(`TMC_ADDR_CFG_A, 8'h10);
		tap(4'hf);
		I_TDO_BUF_BIT = 1'b0;
		tap(4'he);
		I_TDO_BUF_BIT = 1'b1;
		I_ENG_TRST_N = 1'b0;
		wr(`TMC_ADDR_CFG_A, 8'h00);
		tap(4'h1);
		I_ENG_TRST_N = 1'b1;
		tap(4'h8);
		I_ENG_TRST_N = 1'b0;
		I_ENG_TMS = 1'b1;
		wr(`TMC_ADDR_CFG_A, 8'h02);
		k = n_rise;
		wr(`TMC_ADDR_DISC, 8'h09);
		tap(4'ha, 4'he);
		chk("discrete pulses", 8'h01, 8'(n_rise - k));
		wr(`TMC_ADDR_DISC, 8'h04);
		tap(4'h4, 4'he);
		rd(`TMC_ADDR_DISC, 8'h04, 8'hfd);
		end_sim();
	end
endmodule: tap_master_configuration_tb_top
